// file: pkg/safety_spi_pkg.sv
// shared constants, types and checksum for the safety spi status link
// How it works
// - timeout sets flag, requests safe state in diag
// - timeout flag latched until host read
// - read clears flag only if cause gone
// - host repeats read to confirm clearing
// - counter increments entering safe from diag/active
// - no increment from reset above safe lock
// - counter write only in diag, unlocked
// - counter at power down threshold: off
// - status four layout, resets to zero
// - transfer flags gather all frames since last transfer read
// - output feedback mismatch sets bit seven
// - fewer than 24 edges sets short
// - more than 24 edges sets long
// - unknown command sets bad command flag
// - checksum mismatch sets checksum flag
// - clock high at select fall flagged
// - clock high at select rise flagged
// - reset cut frame flagged, all reset zero
package safety_spi_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam logic [3:0] LINK_HALF_CYCLES =
    4'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // ****************************************
  // frame
  // ****************************************
  localparam logic [5:0] FRAME_EDGES = 6'h18;
  localparam logic [5:0] EDGE_MAX    = 6'h3F;
  localparam logic [4:0] LAST_BIT    = 5'h17;
  localparam logic [7:0] CRC_POLY    = 8'h1D;
  localparam logic [7:0] CRC_INIT    = 8'hFF;

  localparam logic [7:0] READ_SAFETY_STATUS_FOUR_CMD = 8'h10;
  localparam logic [7:0] READ_TRANSFER_STATUS_CMD    = 8'h11;
  localparam logic [7:0] WRITE_ERROR_COUNTER_CMD     = 8'h95;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
    logic [7:0] crc;
  } frame_t;

  typedef struct packed {
    logic [2:0] reserved;
    logic       diagnostic_timeout_flag;
    logic [3:0] device_error_counter;
  } safety_error_status_four_t;

  typedef struct packed {
    logic output_feedback_mismatch_flag;
    logic short_frame_flag;
    logic long_frame_flag;
    logic bad_command_flag;
    logic input_checksum_error_flag;
    logic clock_high_at_select_fall_flag;
    logic clock_high_at_select_rise_flag;
    logic reset_terminated_flag;
  } serial_transfer_status_t;

  localparam logic [3:0] COUNTER_MAX = 4'hF;

  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_RESET  = 5'h02,
    ST_DIAG   = 5'h04,
    ST_ACTIVE = 5'h08,
    ST_SAFE   = 5'h10
  } safety_state_t;

  // ****************************************
  // host controller registers
  // ****************************************
  localparam logic [7:0] OFS_COMMAND    = 8'h00;
  localparam logic [7:0] OFS_REPLY      = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

  typedef struct packed {
    logic       confirm;
    logic [7:0] cmd;
    logic [7:0] data;
  } host_command_t;

  typedef struct packed {
    logic reply_crc_bad;
    logic frame_done;
  } host_irq_t;

  typedef struct packed {
    logic reply_crc_bad;
    logic busy;
  } host_status_t;

  // checksum over command and data, msb first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

endpackage

// file: pkg/spi_link_if.sv
// serial link between host controller and safety device
`timescale 1ns/1ps
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_fb;

  // pad feedback of the device serial output
  assign miso_fb = miso;

  modport device (input sclk, input cs_n, input mosi, input miso_fb,
                  output miso);
  modport host   (output sclk, output cs_n, output mosi, input miso);
endinterface

// file: src/safety_spi_device.sv
// safety device end: status registers and serial frame checking
`timescale 1ns/1ps
module safety_spi_device (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  spi_link_if.device                         link,
  input  safety_spi_pkg::safety_state_t      safety_state,
  input  wire logic                          diag_timeout,
  input  wire logic                          cfg_lock,
  input  wire logic                          reset_event,
  input  wire logic [3:0]                    safe_lock_threshold,
  input  wire logic [3:0]                    power_down_threshold,
  output logic                               safe_request,
  output logic                               power_down,
  output logic [3:0]                         error_counter
);

  // ****************************************
  // link input synchronisers
  // ****************************************
  localparam logic [3:0] LINK_IDLE = 4'h4;

  logic [3:0] s1_q, s2_q, s3_q, f_q, p_q, f_d;
  logic       sclk_f, csn_f, mosi_f, fb_f, sclk_p, csn_p;

  // three stages, level accepted once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= LINK_IDLE;
      s2_q <= LINK_IDLE;
      s3_q <= LINK_IDLE;
      f_q  <= LINK_IDLE;
      p_q  <= LINK_IDLE;
    end else begin
      s1_q <= {link.sclk, link.cs_n, link.mosi, link.miso_fb};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
      p_q  <= f_q;
    end
  end

  assign f_d = (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
  assign {sclk_f, csn_f, mosi_f} = f_q[3:1];
  // feedback taken one stage early so it has settled at the rising edge
  assign fb_f = f_d[0];
  assign sclk_p = p_q[3];
  assign csn_p  = p_q[2];

  logic sclk_rise, sclk_fall, cs_fall, cs_rise, in_frame;
  assign in_frame  = ~csn_p & ~csn_f;
  assign sclk_rise = in_frame & sclk_f & ~sclk_p;
  assign sclk_fall = in_frame & ~sclk_f & sclk_p;
  assign cs_fall   = ~csn_f & csn_p;
  assign cs_rise   = csn_f & ~csn_p;

  // ****************************************
  // frame capture
  // ****************************************
  logic [23:0]                       shift_in_q, tx_q;
  logic [5:0]                        rise_cnt_q, fall_cnt_q;
  logic                              miso_q, pend_sdo_q, pend_fall_q;
  logic                              pend_reset_q;
  safety_spi_pkg::frame_t            rx, reply_q, reply_d;

  // edge counters saturate so a runaway frame still reads as long
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rise_cnt_q <= 6'h00;
      fall_cnt_q <= 6'h00;
    end else if (cs_fall) begin
      rise_cnt_q <= 6'h00;
      fall_cnt_q <= 6'h00;
    end else begin
      if (sclk_rise && rise_cnt_q != safety_spi_pkg::EDGE_MAX) begin
        rise_cnt_q <= rise_cnt_q + 6'h01;
      end
      if (sclk_fall && fall_cnt_q != safety_spi_pkg::EDGE_MAX) begin
        fall_cnt_q <= fall_cnt_q + 6'h01;
      end
    end
  end

  // receive shift, msb first on rising edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_in_q <= 24'h000000;
    end else if (sclk_rise) begin
      shift_in_q <= {shift_in_q[22:0], mosi_f};
    end
  end

  // reply shift: first bit at select fall, next on each falling edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_q   <= 24'h000000;
      miso_q <= 1'b0;
    end else if (cs_fall) begin
      miso_q <= reply_q.cmd[7];
      tx_q   <= {reply_q[22:0], 1'b0};
    end else if (sclk_fall) begin
      miso_q <= tx_q[23];
      tx_q   <= {tx_q[22:0], 1'b0};
    end
  end

  assign link.miso = miso_q;

  // per-frame pending conditions, only committed at select rise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_sdo_q   <= 1'b0;
      pend_fall_q  <= 1'b0;
      pend_reset_q <= 1'b0;
    end else if (cs_fall) begin
      pend_sdo_q   <= 1'b0;
      pend_fall_q  <= sclk_f;
      pend_reset_q <= 1'b0;
    end else begin
      // miso is steady here and its feedback has just passed the filter
      if (sclk_rise && (miso_q != fb_f)) begin
        pend_sdo_q <= 1'b1;
      end
      if (in_frame && reset_event) begin
        pend_reset_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // frame evaluation at select rise
  // ****************************************
  safety_spi_pkg::serial_transfer_status_t errs, xfer_q;
  safety_spi_pkg::safety_error_status_four_t stat4;
  logic len_ok, known_cmd, frame_ok, is_rd4, is_rdx, is_wr;
  logic timeout_q, to_prev_q;
  logic [3:0] cnt_q;
  logic [7:0] data_out;

  assign rx        = shift_in_q;
  assign known_cmd = (rx.cmd == safety_spi_pkg::READ_SAFETY_STATUS_FOUR_CMD)
                   | (rx.cmd == safety_spi_pkg::READ_TRANSFER_STATUS_CMD)
                   | (rx.cmd == safety_spi_pkg::WRITE_ERROR_COUNTER_CMD);

  always_comb begin
    errs = '0;
    errs.output_feedback_mismatch_flag  = pend_sdo_q;
    errs.short_frame_flag = (rise_cnt_q < safety_spi_pkg::FRAME_EDGES)
                          | (fall_cnt_q < safety_spi_pkg::FRAME_EDGES);
    errs.long_frame_flag  = (rise_cnt_q > safety_spi_pkg::FRAME_EDGES)
                          | (fall_cnt_q > safety_spi_pkg::FRAME_EDGES);
    len_ok = ~errs.short_frame_flag & ~errs.long_frame_flag;
    errs.bad_command_flag = len_ok & ~known_cmd;
    errs.input_checksum_error_flag =
      len_ok & (rx.crc != safety_spi_pkg::crc8({rx.cmd, rx.data}));
    errs.clock_high_at_select_fall_flag = pend_fall_q;
    errs.clock_high_at_select_rise_flag = sclk_f;
    errs.reset_terminated_flag          = pend_reset_q;
  end

  assign frame_ok = len_ok & ~errs.bad_command_flag
                  & ~errs.input_checksum_error_flag
                  & ~errs.reset_terminated_flag;
  assign is_rd4 = cs_rise & frame_ok
                & (rx.cmd == safety_spi_pkg::READ_SAFETY_STATUS_FOUR_CMD);
  assign is_rdx = cs_rise & frame_ok
                & (rx.cmd == safety_spi_pkg::READ_TRANSFER_STATUS_CMD);
  // locked or outside diag: write ignored, counter untouched
  assign is_wr  = cs_rise & frame_ok & ~cfg_lock
                & (rx.cmd == safety_spi_pkg::WRITE_ERROR_COUNTER_CMD)
                & (safety_state == safety_spi_pkg::ST_DIAG);

  // flags of this frame land together; a transfer read restarts them from its own frame's flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xfer_q <= '0;
    end else if (cs_rise) begin
      if (is_rdx) begin
        xfer_q <= errs;
      end else begin
        xfer_q <= xfer_q | errs;
      end
    end
  end

  // ****************************************
  // safety error status four
  // ****************************************
  logic [4:0] prev_state_q;
  logic       enter_safe, inc;
  logic [3:0] cnt_base;

  // latched while cause is up; read clears only once it has gone
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timeout_q <= 1'b0;
    end else if (is_rd4) begin
      timeout_q <= diag_timeout;
    end else if (diag_timeout) begin
      timeout_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_state_q <= safety_spi_pkg::ST_OFF;
      to_prev_q    <= 1'b0;
    end else begin
      prev_state_q <= safety_state;
      to_prev_q    <= diag_timeout;
    end
  end

  assign enter_safe = (safety_state == safety_spi_pkg::ST_SAFE)
                    & (prev_state_q != safety_spi_pkg::ST_SAFE);
  assign inc = enter_safe
             & ((prev_state_q == safety_spi_pkg::ST_DIAG)
              | (prev_state_q == safety_spi_pkg::ST_ACTIVE)
              | ((prev_state_q == safety_spi_pkg::ST_RESET)
               & (cnt_base <= safe_lock_threshold)));
  assign cnt_base = is_wr ? rx.data[3:0] : cnt_q;

  // a write landing with a safe entry still counts the entry
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 4'h0;
    end else if (inc && cnt_base != safety_spi_pkg::COUNTER_MAX) begin
      cnt_q <= cnt_base + 4'h1;
    end else begin
      cnt_q <= cnt_base;
    end
  end

  // timeout in diag asks the state machine for safe; entry then counts once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      safe_request <= 1'b0;
      power_down   <= 1'b0;
    end else begin
      safe_request <= diag_timeout & ~to_prev_q
                    & (safety_state == safety_spi_pkg::ST_DIAG);
      power_down   <= (cnt_q == power_down_threshold);
    end
  end

  assign error_counter = cnt_q;

  always_comb begin
    stat4 = '0;
    stat4.diagnostic_timeout_flag = timeout_q;
    stat4.device_error_counter    = cnt_q;
  end

  // ****************************************
  // reply for the next frame
  // ****************************************
  // snapshot before commit, so a read shows earlier frames only
  always_comb begin
    data_out = 8'h00;
    if (is_rd4) begin
      data_out = stat4;
    end else if (is_rdx) begin
      data_out = xfer_q;
    end
    reply_d.cmd  = rx.cmd;
    reply_d.data = data_out;
    reply_d.crc  = safety_spi_pkg::crc8({rx.cmd, data_out});
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reply_q <= '0;
    end else if (cs_rise) begin
      reply_q <= reply_d;
    end
  end

endmodule // safety_spi_device

// file: src/safety_spi_host.sv
// host end: apb controlled frame engine driving the serial link
`timescale 1ns/1ps
module safety_spi_host (
  input  wire logic        clk,
  input  wire logic        resetn,
  spi_link_if.host         link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  typedef enum logic [5:0] {
    H_IDLE  = 6'h01,
    H_SETUP = 6'h02,
    H_HIGH  = 6'h04,
    H_LOW   = 6'h08,
    H_TAIL  = 6'h10,
    H_GAP   = 6'h20
  } host_state_t;

  // ****************************************
  // apb decode
  // ****************************************
  host_state_t                    state_q;
  safety_spi_pkg::host_command_t  wcmd;
  safety_spi_pkg::host_irq_t      ist_q, ien_q, iset;
  safety_spi_pkg::host_status_t   hstat;
  safety_spi_pkg::frame_t         frame_q, rx_q, reply_q;
  logic again_q, crc_bad_q, busy, start, wr_acc, rd_setup, mapped;

  assign pready   = 1'b1;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign wcmd     = pwdata[16:0];
  assign busy     = (state_q != H_IDLE) | again_q;
  // a command while busy is dropped; software polls busy first
  assign start    = wr_acc & (paddr == safety_spi_pkg::OFS_COMMAND) & ~busy;
  assign mapped   = (paddr == safety_spi_pkg::OFS_COMMAND)
                  | (paddr == safety_spi_pkg::OFS_REPLY)
                  | (paddr == safety_spi_pkg::OFS_STATUS)
                  | (paddr == safety_spi_pkg::OFS_IRQ_STATUS)
                  | (paddr == safety_spi_pkg::OFS_IRQ_CLEAR)
                  | (paddr == safety_spi_pkg::OFS_IRQ_ENABLE);

  assign hstat.busy          = busy;
  assign hstat.reply_crc_bad = crc_bad_q;

  // read data registered in setup so it is stable in access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= ~mapped;
      case (paddr)
        safety_spi_pkg::OFS_REPLY:      prdata <= 32'(reply_q);
        safety_spi_pkg::OFS_STATUS:     prdata <= 32'(hstat);
        safety_spi_pkg::OFS_IRQ_STATUS: prdata <= 32'(ist_q);
        safety_spi_pkg::OFS_IRQ_ENABLE: prdata <= 32'(ien_q);
        default:                        prdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ist_q <= '0;
      ien_q <= '0;
      irq   <= 1'b0;
    end else begin
      // set beats a clear arriving in the same cycle
      if (wr_acc && paddr == safety_spi_pkg::OFS_IRQ_CLEAR) begin
        ist_q <= (ist_q & ~pwdata[1:0]) | iset;
      end else begin
        ist_q <= ist_q | iset;
      end
      if (wr_acc && paddr == safety_spi_pkg::OFS_IRQ_ENABLE) begin
        ien_q <= pwdata[1:0];
      end
      irq <= |(ist_q & ien_q);
    end
  end

  // ****************************************
  // miso synchroniser
  // ****************************************
  logic m1_q, m2_q, m3_q, miso_f;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m1_q   <= 1'b0;
      m2_q   <= 1'b0;
      m3_q   <= 1'b0;
      miso_f <= 1'b0;
    end else begin
      m1_q <= link.miso;
      m2_q <= m1_q;
      m3_q <= m2_q;
      if (m2_q == m3_q) begin
        miso_f <= m3_q;
      end
    end
  end

  // ****************************************
  // frame engine
  // ****************************************
  logic [3:0]  div_q;
  logic [4:0]  bit_q;
  logic [23:0] tx_q;
  logic        tick, sclk_q, csn_q, mosi_q;

  assign tick = (div_q == safety_spi_pkg::LINK_HALF_CYCLES - 4'h1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 4'h0;
    end else if (state_q == H_IDLE || tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // clock only toggles inside a frame; select moves while it is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= H_IDLE;
      sclk_q    <= 1'b0;
      csn_q     <= 1'b1;
      mosi_q    <= 1'b0;
      tx_q      <= 24'h000000;
      bit_q     <= 5'h00;
      frame_q   <= '0;
      again_q   <= 1'b0;
      reply_q   <= '0;
      crc_bad_q <= 1'b0;
      iset      <= '0;
    end else begin
      iset <= '0;
      case (state_q)
        H_IDLE: begin
          if (start) begin
            frame_q <= {wcmd.cmd, wcmd.data,
                        safety_spi_pkg::crc8({wcmd.cmd, wcmd.data})};
            tx_q    <= {wcmd.cmd, wcmd.data,
                        safety_spi_pkg::crc8({wcmd.cmd, wcmd.data})};
            mosi_q  <= wcmd.cmd[7];
            again_q <= wcmd.confirm;
            csn_q   <= 1'b0;
            bit_q   <= 5'h00;
            state_q <= H_SETUP;
          end else if (again_q) begin
            tx_q    <= frame_q;
            mosi_q  <= frame_q.cmd[7];
            again_q <= 1'b0;
            csn_q   <= 1'b0;
            bit_q   <= 5'h00;
            state_q <= H_SETUP;
          end
        end
        H_SETUP, H_LOW: begin
          if (tick) begin
            sclk_q  <= 1'b1;
            state_q <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tick) begin
            sclk_q <= 1'b0;
            bit_q  <= bit_q + 5'h01;
            if (bit_q == safety_spi_pkg::LAST_BIT) begin
              state_q <= H_TAIL;
            end else begin
              mosi_q  <= tx_q[22];
              tx_q    <= {tx_q[22:0], 1'b0};
              state_q <= H_LOW;
            end
          end
        end
        H_TAIL: begin
          if (tick) begin
            csn_q   <= 1'b1;
            state_q <= H_GAP;
          end
        end
        H_GAP: begin
          // gap lets the device see select high before the next frame
          if (tick) begin
            reply_q   <= rx_q;
            crc_bad_q <= rx_q.crc
                      != safety_spi_pkg::crc8({rx_q.cmd, rx_q.data});
            iset.frame_done    <= 1'b1;
            iset.reply_crc_bad <= rx_q.crc
                      != safety_spi_pkg::crc8({rx_q.cmd, rx_q.data});
            state_q <= H_IDLE;
          end
        end
        default: begin
          state_q <= H_IDLE;
          csn_q   <= 1'b1;
          sclk_q  <= 1'b0;
        end
      endcase
    end
  end

  // device answers a fall later than the next fall: take miso mid low phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_q <= '0;
    end else if ((state_q == H_LOW || state_q == H_TAIL)
                 && div_q == safety_spi_pkg::LINK_HALF_CYCLES - 4'h2) begin
      rx_q <= {rx_q[22:0], miso_f};
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = csn_q;
  assign link.mosi = mosi_q;

endmodule // safety_spi_host

// file: verif/safety_spi_link_chk.sv
// wire assertions for the serial link between host and device
`timescale 1ns/1ps
module safety_spi_link_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_fb
);
  logic [5:0] rise_q;
  logic       sclk_q;
  // rising clock count of the open frame, cleared while deselected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rise_q <= 6'h00;
    end else if (cs_n) begin
      rise_q <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rise_q <= rise_q + 6'h01;
    end
  end
  // previous clock level for edge detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence lead_in; !sclk[*4] ##1 sclk; endsequence
  sequence high_ph; sclk[*4] ##1 !sclk; endsequence
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("clock high while deselected");
  a_select_fall: assert property ($fell(cs_n) |-> lead_in)
    else $error("bad lead-in after select");
  a_edge_count: assert property ($rose(cs_n) |-> rise_q == 6'h18)
    else $error("frame edge count wrong");
  a_high_phase: assert property ($rose(sclk) |-> high_ph)
    else $error("clock high phase wrong");
  a_low_phase: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("clock low phase short");
  a_frame_gap: assert property ($rose(cs_n) |-> cs_n[*4])
    else $error("gap after frame short");
  a_mosi_steady: assert property ($rose(sclk) |=> $stable(mosi)[*3])
    else $error("data moved in high phase");
  a_feedback_loop: assert property (miso_fb == miso)
    else $error("output feedback differs");
endmodule // safety_spi_link_chk

// file: verif/safety_spi_error_status_tb.sv
// bench: host and device joined, plus a second device on a raw driver
`timescale 1ns/1ps
module safety_spi_error_status_tb;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        dto, lock, rev2, sreq, pdn;
  logic [7:0]  paddr, d;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  slt, pdt, cnt, ec;
  logic [23:0] r;
  logic [24:0] c, tv [6];
  int          bad_count, n_checks, seed;
  safety_spi_pkg::safety_state_t st;
  spi_link_if lnk ();
  spi_link_if lnk2 ();
  safety_spi_host i_safety_spi_host (.clk(clk), .resetn(resetn), .link(lnk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
  safety_spi_device i_safety_spi_device (.clk(clk), .resetn(resetn),
    .link(lnk), .safety_state(st), .diag_timeout(dto), .cfg_lock(lock),
    .reset_event(1'b0), .safe_lock_threshold(slt),
    .power_down_threshold(pdt), .safe_request(sreq), .power_down(pdn),
    .error_counter(cnt));
  safety_spi_device i_safety_spi_device_b (.clk(clk), .resetn(resetn),
    .link(lnk2), .safety_state(st), .diag_timeout(dto), .cfg_lock(lock),
    .reset_event(rev2), .safe_lock_threshold(slt),
    .power_down_threshold(pdt), .safe_request(), .power_down(),
    .error_counter());
  safety_spi_link_chk i_safety_spi_link_chk (.clk(clk), .resetn(resetn),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso),
    .miso_fb(lnk.miso_fb));
  // compare, count, report
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tmo;
    bad_count++;
    $display("unexpected at %0t: timeout", $time);
    final_report();
  endtask
  // one apb transfer, request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) tmo();
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  // host frame: command, wait for idle, fetch reply
  task automatic hf(input logic [7:0] k, v, input logic f = 1'b0);
    int n;
    n = 0;
    apb(1'b1, safety_spi_pkg::OFS_COMMAND, {15'h0000, f, k, v});
    repeat (2) @(posedge clk);
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 500) begin
      apb(1'b0, safety_spi_pkg::OFS_STATUS, 32'h0);
      n++;
    end
    if (n == 500) tmo();
    repeat (2) @(posedge clk);
    apb(1'b0, safety_spi_pkg::OFS_REPLY, 32'h0);
  endtask
  // frame word with checksum worked out here
  function automatic logic [23:0] fw(input logic [7:0] k, v);
    logic [7:0]  s;
    logic [15:0] kv;
    s = 8'hFF;
    kv = {k, v};
    for (int i = 15; i >= 0; i--) begin
      s = {s[6:0], 1'b0} ^ ((s[7] ^ kv[i]) ? 8'h1D : 8'h00);
    end
    return {k, v, s};
  endfunction
  // raw frame; hi keeps the clock high at both select edges
  task automatic bb(input logic [5:0] n, input logic hi, rv,
                    input logic [23:0] w);
    {rev2, lnk2.sclk, lnk2.cs_n} <= {rv, hi, 1'b0};
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      {lnk2.mosi, lnk2.sclk} <= {w[23], 1'b0};
      w = {w[22:0], w[23]};
      repeat (4) @(posedge clk);
      lnk2.sclk <= 1'b1;
      repeat (4) @(posedge clk);
      r = {r[22:0], lnk2.miso};
    end
    lnk2.sclk <= hi;
    repeat (4) @(posedge clk);
    {rev2, lnk2.cs_n, lnk2.mosi} <= {2'b01, ~lnk2.mosi};
    @(posedge clk);
    lnk2.sclk <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic go(input safety_spi_pkg::safety_state_t s);
    @(posedge clk);
    st <= s;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // main sequence
  initial begin
    seed = 32'h32A51811;
    {resetn, psel, penable, pwrite, dto, lock, rev2, paddr, pwdata} = '0;
    {slt, pdt, st} = {8'h0F, safety_spi_pkg::ST_DIAG};
    {lnk2.sclk, lnk2.cs_n, lnk2.mosi} = 3'b010;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(pslverr, 1'b1);
    apb(1'b1, safety_spi_pkg::OFS_IRQ_ENABLE, 32'h3);
    ec = 4'($random(seed)) & 4'h7;
    hf(safety_spi_pkg::WRITE_ERROR_COUNTER_CMD, {4'h0, ec});
    chk(cnt, ec);
    chk(irq, 1'b1);
    apb(1'b1, safety_spi_pkg::OFS_IRQ_CLEAR, 32'h3);
    apb(1'b0, safety_spi_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
    lock <= 1'b1;
    hf(safety_spi_pkg::WRITE_ERROR_COUNTER_CMD, {4'h0, ~ec});
    chk(cnt, ec);
    $display("test counter write done");
    dto <= 1'b1;
    @(posedge clk);
    #1 chk(sreq, 1'b1);
    go(safety_spi_pkg::ST_SAFE);
    dto <= 1'b0;
    ec++;
    chk(cnt, ec);
    for (int i = 0; i < 3; i++) begin
      hf(safety_spi_pkg::READ_SAFETY_STATUS_FOUR_CMD, 8'h00, i == 0);
      chk(rd[15:8], {3'b000, i == 0, ec});
    end
    go(safety_spi_pkg::ST_ACTIVE);
    go(safety_spi_pkg::ST_SAFE);
    ec++;
    chk(cnt, ec);
    for (int i = 0; i < 2; i++) begin
      slt <= ec - 4'(1 - i);
      go(safety_spi_pkg::ST_RESET);
      go(safety_spi_pkg::ST_SAFE);
      ec = ec + 4'(i);
      chk(cnt, ec);
    end
    pdt <= ec;
    go(safety_spi_pkg::ST_SAFE);
    chk(pdn, 1'b1);
    $display("test state counter done");
    tv = '{25'h804011, 25'hF02011, 25'hC40611, 25'hC10811, 25'hC0105A,
           25'hC20111};
    for (int k = 0; k < 6; k++) begin
      c = tv[k];
      d = 8'($random(seed));
      bb(c[24:19], c[18], c[17], fw(c[7:0], d) ^ {23'h0, c[16]});
      repeat (2) bb(6'h18, 1'b0, 1'b0, fw(8'h11, d));
      chk(r[15:8], c[15:8]);
    end
    $display("test transfer flags done");
    final_report();
  end
endmodule // safety_spi_error_status_tb
